// ===== rsu_controller.v
// Contract
// - keep two previous-state debug records
// - one-hot cause bits 30 down to 26
// - simultaneous causes: highest bit wins
// - bits 25:24 hold state at exit
// - bits 23:0 hold boot address used
// - capture before first application flags bad
// - registers writable only in factory image
// - request in factory or user mode copies update into control, reconfigures
// - errors clear control; request loads update
// - status updated before factory reload
// - watchdog 29-bit down counter from control
// - reload is twelve bits plus constant
// - watchdog clocked by oscillator or user clock
// - watchdog runs only in application user mode
// - expiry sets status bit, loads factory
// - control bit 35 enable, page, timer fields
// - current status bits 31:30 give state
`include "rsu_defines.vh"
module rsu_controller #(
  parameter LOAD_CYCLES = 16
) (
  input  wire        CLK,
  input  wire        RESET,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  output reg  [1:0]  S_AXI_BRESP,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  input  wire [11:0] S_AXI_ARADDR,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  input  wire        RECONFIG_REQUEST,
  input  wire        WATCHDOG_RELOAD,
  input  wire        EXT_CONFIG_RESET,
  input  wire        CRC_ERROR,
  input  wire        CONFIG_STATUS_PIN_N,
  input  wire        OSC_TICK,
  input  wire        USER_SUPPLIED_CLOCK,
  output reg         FACTORY_IMAGE,
  output reg         LOAD_START,
  output reg  [23:0] BOOT_ADDRESS
);
  // ***********************************************************
  // state machine
  // ***********************************************************
  localparam ST_FACTORY = 4'b0001;
  localparam ST_LOAD    = 4'b0010;
  localparam ST_USER    = 4'b0100;
  localparam ST_RECONF  = 4'b1000;

  reg  [3:0]            state_r;
  reg  [3:0]            state_nxt;
  reg  [`CTL_WIDTH-1:0] update_r;
  reg  [`CTL_WIDTH-1:0] control_r;
  reg  [30:0]           prev_one_r;
  reg  [30:0]           prev_two_r;
  reg                   entered_app_r;
  reg                   wd_status_r;
  reg                   clksel_r;
  reg  [15:0]           load_cnt_r;
  reg  [4:0]            cause_r;
  reg                   err_to_factory_r;
  reg  [4:0]            sync1_r;
  reg  [4:0]            sync2_r;
  reg  [4:0]            sync3_r;
  reg  [7:0]            req_cnt_r;
  reg  [7:0]            rld_cnt_r;
  reg                   req_seen_r;
  reg                   rld_seen_r;
  reg                   aw_held_r;
  reg                   w_held_r;
  reg  [11:0]           aw_addr_r;
  reg  [31:0]           w_data_r;
  reg  [3:0]            w_strb_r;
  wire [28:0]           wd_count;
  wire                  wd_expired;

  // encoded master state for status fields
  function [1:0] enc_state;
    input [3:0] s;
    begin
      case (s)
        ST_FACTORY: enc_state = `MS_FACTORY;
        ST_LOAD:    enc_state = `MS_APP_LOAD;
        ST_USER:    enc_state = `MS_APP_USER;
        default:    enc_state = `MS_RECONFIG;
      endcase
    end
  endfunction

  // byte-lane merge of a 32-bit word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[k*8 +: 8] = din[k*8 +: 8];
    end
  endfunction

  // ***********************************************************
  // input synchronisers: req, reload, ext reset, crc, pin
  // ***********************************************************
  wire [4:0] raw_in = {RECONFIG_REQUEST, WATCHDOG_RELOAD,
                       EXT_CONFIG_RESET, CRC_ERROR,
                       ~CONFIG_STATUS_PIN_N};
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // watchdog timebase: oscillator or user clock, both synchronised
  reg [1:0] osc_s_r;
  reg [1:0] usr_s_r;
  reg       tb_prev_r;
  wire      tb_now = clksel_r ? usr_s_r[1] : osc_s_r[1];
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      osc_s_r   <= 2'h0;
      usr_s_r   <= 2'h0;
      tb_prev_r <= 1'b0;
    end
    else
    begin
      osc_s_r   <= {osc_s_r[0], OSC_TICK};
      usr_s_r   <= {usr_s_r[0], USER_SUPPLIED_CLOCK};
      tb_prev_r <= tb_now;
    end
  end
  wire wd_tick = tb_now & ~tb_prev_r;

  // strobes only count once held the minimum time
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      req_cnt_r  <= 8'h00;
      rld_cnt_r  <= 8'h00;
      req_seen_r <= 1'b0;
      rld_seen_r <= 1'b0;
    end
    else
    begin
      req_cnt_r  <= sync2_r[4] ? req_cnt_r + {7'h00, ~req_seen_r} : 8'h00;
      req_seen_r <= sync2_r[4] && (req_seen_r ||
                    req_cnt_r == (`STROBE_CYCLES - 1));
      rld_cnt_r  <= sync2_r[3] ? rld_cnt_r + {7'h00, ~rld_seen_r} : 8'h00;
      rld_seen_r <= sync2_r[3] && (rld_seen_r ||
                    rld_cnt_r == (`STROBE_CYCLES - 1));
    end
  end
  wire req_go = sync2_r[4] && !req_seen_r &&
                req_cnt_r == (`STROBE_CYCLES - 1);
  wire rld_go = sync2_r[3] && !rld_seen_r &&
                rld_cnt_r == (`STROBE_CYCLES - 1);

  // causes gathered in order of precedence
  wire [4:0] cause_now = {sync2_r[2] & ~sync3_r[2],
                          sync2_r[1] & ~sync3_r[1],
                          sync2_r[0] & ~sync3_r[0],
                          wd_expired,
                          req_go & (state_r == ST_FACTORY ||
                                    state_r == ST_USER)};
  wire [4:0] cause_win = cause_now[4] ? 5'b10000 :
                         cause_now[3] ? 5'b01000 :
                         cause_now[2] ? 5'b00100 :
                         cause_now[1] ? 5'b00010 :
                         cause_now[0] ? 5'b00001 : 5'b00000;
  wire any_cause = |cause_now;

  // ***********************************************************
  // watchdog instance
  // ***********************************************************
  rsu_watchdog #(
    .WD_WIDTH (29)
  ) u_wdog (
    .clk         (CLK),
    .reset       (RESET),
    .run         (state_r == ST_USER && control_r[`CTL_WATCHDOG_ENABLE_BIT]),
    .tick        (wd_tick),
    .reload      (rld_go),
    .timeout_val (control_r[`CTL_WD_HI:`CTL_WD_LO]),
    .count_r     (wd_count),
    .expired_r   (wd_expired)
  );

  // next state of master machine
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_FACTORY: if (any_cause) state_nxt = ST_RECONF;
      ST_LOAD:    if (any_cause) state_nxt = ST_RECONF;
                  else if (load_cnt_r == 16'h0000) state_nxt = ST_USER;
      ST_USER:    if (any_cause) state_nxt = ST_RECONF;
      ST_RECONF:  state_nxt = err_to_factory_r ? ST_FACTORY : ST_LOAD;
      default:    state_nxt = ST_FACTORY;
    endcase
  end

  // ***********************************************************
  // master machine, control register and records
  // ***********************************************************
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      state_r          <= ST_FACTORY;
      control_r        <= `CTL_RESET;
      prev_one_r       <= `REC_BAD_CAPTURE;
      prev_two_r       <= `REC_BAD_CAPTURE;
      entered_app_r    <= 1'b0;
      wd_status_r      <= 1'b0;
      load_cnt_r       <= 16'h0000;
      cause_r          <= 5'h00;
      err_to_factory_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_LOAD && load_cnt_r != 16'h0000)
        load_cnt_r <= load_cnt_r - 16'h0001;
      if (state_r == ST_USER)
        entered_app_r <= 1'b1;
      if (state_r != ST_RECONF && any_cause)
      begin
        cause_r          <= cause_win;
        err_to_factory_r <= ~cause_win[0];
        if (cause_win[1])
          wd_status_r <= 1'b1;
        if (cause_win[0])
          control_r <= update_r;
        else
          control_r <= `CTL_RESET;
        // only leaving an application produces a record
        if (state_r != ST_FACTORY)
        begin
          prev_two_r <= prev_one_r;
          prev_one_r <= {cause_win, enc_state(state_r),
                         control_r[`CTL_PAGE_HI:`CTL_PAGE_LO],
                         2'b00};
        end
      end
      if (state_r == ST_RECONF && !err_to_factory_r)
        load_cnt_r <= LOAD_CYCLES[15:0];
    end
  end

  // ***********************************************************
  // axi4-lite write channel
  // ***********************************************************
  wire factory = (state_r == ST_FACTORY);
  wire do_wr   = aw_held_r && w_held_r && !S_AXI_BVALID;
  wire wr_ok   = (aw_addr_r == `OFS_UPDATE_LO) ||
                 (aw_addr_r == `OFS_UPDATE_HI) ||
                 (aw_addr_r == `OFS_STATUS);
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'h0;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 12'h000;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      update_r      <= `CTL_RESET;
      clksel_r      <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_held_r && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_held_r && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held_r     <= 1'b1;
        aw_addr_r     <= {S_AXI_AWADDR[11:2], 2'b00};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held_r     <= 1'b1;
        w_data_r     <= S_AXI_WDATA;
        w_strb_r     <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_wr)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_ok && factory) ? 2'h0 : 2'h2;
        if (factory && aw_addr_r == `OFS_UPDATE_LO)
          update_r[31:0] <= merge(update_r[31:0], w_data_r, w_strb_r);
        if (factory && aw_addr_r == `OFS_UPDATE_HI && w_strb_r[0])
          update_r[38:32] <= w_data_r[6:0];
        if (factory && aw_addr_r == `OFS_STATUS && w_strb_r[0])
          clksel_r <= w_data_r[1];
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // ***********************************************************
  // axi4-lite read channel
  // ***********************************************************
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h00000000;
    case ({S_AXI_ARADDR[11:2], 2'b00})
      `OFS_UPDATE_LO:  rd_mux = update_r[31:0];
      `OFS_UPDATE_HI:  rd_mux = {25'h0000000, update_r[38:32]};
      `OFS_CONTROL_LO: rd_mux = control_r[31:0];
      `OFS_CONTROL_HI: rd_mux = {25'h0000000, control_r[38:32]};
      `OFS_CURRENT:    rd_mux = factory ?
        {enc_state(state_r), 6'h00, BOOT_ADDRESS} :
        {enc_state(state_r), control_r[`CTL_WATCHDOG_ENABLE_BIT], wd_count};
      `OFS_PREV_ONE:   rd_mux = entered_app_r ? {1'b0, prev_one_r} :
                                {1'b0, `REC_BAD_CAPTURE};
      `OFS_PREV_TWO:   rd_mux = entered_app_r ? {1'b0, prev_two_r} :
                                {1'b0, `REC_BAD_CAPTURE};
      `OFS_STATUS:     rd_mux = {25'h0000000, cause_r,
                                 clksel_r, wd_status_r};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge CLK)
  begin
    if (RESET)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= 2'h0;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_mux;
        S_AXI_RRESP   <= (S_AXI_ARADDR[11:0] <= `OFS_STATUS) ? 2'h0 : 2'h2;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // outputs toward the configuration loader
  always @(posedge CLK)
  begin
    if (RESET)
    begin
      FACTORY_IMAGE <= 1'b1;
      LOAD_START    <= 1'b0;
      BOOT_ADDRESS  <= 24'h000000;
    end
    else
    begin
      FACTORY_IMAGE <= (state_nxt == ST_FACTORY);
      LOAD_START    <= (state_r == ST_RECONF);
      BOOT_ADDRESS  <= {control_r[`CTL_PAGE_HI:`CTL_PAGE_LO], 2'b00};
    end
  end
endmodule

// ===== rsu_defines.vh
`ifndef RSU_DEFINES_VH
`define RSU_DEFINES_VH
// ***********************************************************
// register byte offsets on the bus
// ***********************************************************
`define OFS_UPDATE_LO   12'h000
`define OFS_UPDATE_HI   12'h004
`define OFS_CONTROL_LO  12'h008
`define OFS_CONTROL_HI  12'h00c
`define OFS_CURRENT     12'h010
`define OFS_PREV_ONE    12'h014
`define OFS_PREV_TWO    12'h018
`define OFS_STATUS      12'h01c
// ***********************************************************
// control / update register fields (39 bits)
// ***********************************************************
`define CTL_WIDTH       39
`define CTL_RESERVED2   38
`define CTL_EARLY_DONE  37
`define CTL_OSC_INT     36
`define CTL_WATCHDOG_ENABLE_BIT       35
`define CTL_RESERVED1   34
`define CTL_PAGE_HI     33
`define CTL_PAGE_LO     12
`define CTL_WD_HI       11
`define CTL_WD_LO       0
`define CTL_RESET       39'h0000000000
// ***********************************************************
// previous-state record fields, and low bits of the watchdog reload value
// ***********************************************************
`define CAUSE_EXT       30
`define CAUSE_CRC       29
`define CAUSE_PIN       28
`define CAUSE_WDOG      27
`define CAUSE_USER      26
`define REC_STATE_HI    25
`define REC_STATE_LO    24
`define REC_BAD_CAPTURE 31'h7fffffff
`define WD_LOW_BITS     17'h00008
// ***********************************************************
// timing
// ***********************************************************
`define CLK_PERIOD_NS   10
`define STROBE_MIN_NS   250
`define STROBE_CYCLES   ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ***********************************************************
// master state encoding seen in status fields
// ***********************************************************
`define MS_FACTORY      2'h0
`define MS_APP_LOAD     2'h1
`define MS_APP_USER     2'h2
`define MS_RECONFIG     2'h3
`endif

// ===== rsu_watchdog.v
`include "rsu_defines.vh"
// ***********************************************************
// 29-bit user watchdog, ticks on a synchronised timebase
// ***********************************************************
module rsu_watchdog #(
  parameter WD_WIDTH = 29
) (
  input  wire                clk,
  input  wire                reset,
  input  wire                run,
  input  wire                tick,
  input  wire                reload,
  input  wire [11:0]         timeout_val,
  output reg  [WD_WIDTH-1:0] count_r,
  output reg                 expired_r
);
  // full reload value: upper 12 bits from software, constant low part
  wire [WD_WIDTH-1:0] load_val = {timeout_val, `WD_LOW_BITS};

  // down counter, held at load value unless running
  always @(posedge clk)
  begin
    if (reset || !run || reload)
    begin
      count_r   <= load_val;
      expired_r <= 1'b0;
    end
    else if (tick)
    begin
      if (count_r == {WD_WIDTH{1'b0}})
        expired_r <= 1'b1;
      else
        count_r <= count_r - {{(WD_WIDTH-1){1'b0}}, 1'b1};
    end
    else
      expired_r <= 1'b0;
  end
endmodule

// ===== rsu_props.sv
module rsu_props (
  input wire        CLK,
  input wire        RESET,
  input wire        S_AXI_BVALID,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [11:0] S_AXI_ARADDR,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP,
  input wire        RECONFIG_REQUEST,
  input wire        FACTORY_IMAGE,
  input wire        LOAD_START,
  input wire [23:0] BOOT_ADDRESS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // ****************
  // port relations
  // ****************
  a_reset_idle: assert property (
    $fell(RESET) |-> FACTORY_IMAGE && !LOAD_START && BOOT_ADDRESS == 24'h0)
    else $error("reset state wrong");
  a_load_pulse: assert property (LOAD_START |=> !LOAD_START)
    else $error("load pulse too long");
  a_factory_zero: assert property (
    $rose(FACTORY_IMAGE) ##2 1 |-> BOOT_ADDRESS == 24'h0)
    else $error("factory address not zero");
  a_addr_align: assert property (BOOT_ADDRESS[1:0] == 2'h0)
    else $error("boot address misaligned");
  a_exit_by_req: assert property (
    $fell(FACTORY_IMAGE) ##1 !FACTORY_IMAGE
    |-> $past(RECONFIG_REQUEST, 21))
    else $error("left factory without held request");
  a_write_factory: assert property (
    S_AXI_BVALID && S_AXI_BRESP == 2'h0 |-> FACTORY_IMAGE)
    else $error("write accepted outside factory");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  a_read_unmapped: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 12'h01c
    |=> S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read answered wrongly");
  c_load: cover property (LOAD_START);
  c_back: cover property ($rose(FACTORY_IMAGE));
  c_refused: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule
bind rsu_controller rsu_props props_u (.*);

// ===== user_logic_model.sv
module user_logic_model (
  input  wire CLK,
  input  wire req_go,
  input  wire rld_go,
  output wire RECONFIG_REQUEST,
  output wire WATCHDOG_RELOAD
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 30;
  int req_cnt = 0;
  int rld_cnt = 0;
  // ****************
  // strobe stretchers
  // ****************
  // each strobe stays high 300 ns, clear of the 250 ns minimum
  always @(posedge CLK)
  begin
    req_cnt <= req_go ? HOLD : (req_cnt > 0 ? req_cnt - 1 : 0);
    rld_cnt <= rld_go ? HOLD : (rld_cnt > 0 ? rld_cnt - 1 : 0);
  end
  assign RECONFIG_REQUEST = req_cnt != 0;
  assign WATCHDOG_RELOAD = rld_cnt != 0;
endmodule

// ===== testbench.sv
`include "rsu_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOADC = 8;
  localparam int TICK = 1024; // watchdog timebase period in clocks
  logic        CLK = 1'h0;
  logic        RESET = 1'h1;
  logic        S_AXI_AWVALID = 1'h0;
  logic [11:0] S_AXI_AWADDR = 12'h000;
  logic        S_AXI_WVALID = 1'h0;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic        S_AXI_BREADY = 1'h0;
  logic        S_AXI_ARVALID = 1'h0;
  logic [11:0] S_AXI_ARADDR = 12'h000;
  logic        S_AXI_RREADY = 1'h0;
  logic        EXT_CONFIG_RESET = 1'h0;
  logic        CRC_ERROR = 1'h0;
  logic        CONFIG_STATUS_PIN_N = 1'h1;
  logic        req_go = 1'h0;
  logic        rld_go = 1'h0;
  logic [9:0]  osc_div = 10'h000;
  wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire         S_AXI_RVALID, FACTORY_IMAGE, LOAD_START, OSC_TICK;
  wire         RECONFIG_REQUEST, WATCHDOG_RELOAD, USER_SUPPLIED_CLOCK;
  wire [1:0]   S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0]  S_AXI_RDATA;
  wire [23:0]  BOOT_ADDRESS;
  int          miscompares = 0;
  int          checked = 0;
  int          n;
  logic [31:0] rd;
  logic [1:0]  rs;
  rsu_controller #(.LOAD_CYCLES(LOADC)) dut_u (.*);
  user_logic_model partner_u (.*);
  // clock, and slow timebases for the watchdog
  always #5 CLK = ~CLK;
  always @(posedge CLK) osc_div <= osc_div + 10'h001;
  assign OSC_TICK = osc_div[9];
  assign USER_SUPPLIED_CLOCK = osc_div[8];
  // ****************
  // helpers
  // ****************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    while (aw || w)
    begin
      @(posedge CLK);
      aw = aw && S_AXI_AWREADY !== 1'h1;
      w = w && S_AXI_WREADY !== 1'h1;
      S_AXI_AWVALID <= aw;
      S_AXI_WVALID <= w;
    end
    while (S_AXI_BVALID !== 1'h1) @(posedge CLK);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
  endtask
  // rready offered with the address, data taken where rvalid is seen
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit ar;
    ar = 1;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    while (ar)
    begin
      @(posedge CLK);
      ar = S_AXI_ARREADY !== 1'h1;
      S_AXI_ARVALID <= ar;
    end
    while (S_AXI_RVALID !== 1'h1) @(posedge CLK);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
  endtask
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] m,
            input logic [31:0] e);
    axi_rd(a, rd, rs);
    chk(nm, e, rd & m);
  endtask
  task wchk(input string nm, input logic [11:0] a, input logic [31:0] d,
            input logic [1:0] e);
    axi_wr(a, d, rs);
    chk(nm, {30'h0, e}, {30'h0, rs});
  endtask
  task kick(input logic rld);
    @(posedge CLK);
    req_go <= !rld;
    rld_go <= rld;
    @(posedge CLK);
    req_go <= 1'h0;
    rld_go <= 1'h0;
  endtask
  task wait_fi(input logic lvl, input int lim);
    n = 0;
    while (FACTORY_IMAGE !== lvl && n < lim)
    begin
      @(posedge CLK);
      n++;
    end
    chk("factory", {31'h0, lvl}, {31'h0, FACTORY_IMAGE});
  endtask
  task finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task t_reset;
    rchk("state", `OFS_CURRENT, 32'hc0000000, 32'h0);
    rchk("rec_one", `OFS_PREV_ONE, '1, `REC_BAD_CAPTURE);
    rchk("rec_two", `OFS_PREV_TWO, '1, `REC_BAD_CAPTURE);
    rchk("ctl_lo", `OFS_CONTROL_LO, '1, 32'h0);
    rchk("unmapped", 12'h020, '1, 32'h0);
    chk("unmapped_resp", 32'h2, {30'h0, rs});
  endtask
  // page 22'h123 with watchdog on, then reach user mode
  task t_boot;
    wchk("upd_lo", `OFS_UPDATE_LO, 32'h00123000, 2'h0);
    wchk("upd_hi", `OFS_UPDATE_HI, 32'h00000038, 2'h0);
    wchk("ctl_ro", `OFS_CONTROL_LO, 32'h1, 2'h2);
    kick(1'h0);
    wait_fi(1'h0, 200);
    repeat (2) @(posedge CLK);
    chk("boot_addr", 32'h48c, {8'h0, BOOT_ADDRESS});
    rchk("ctl_lo", `OFS_CONTROL_LO, '1, 32'h00123000);
    rchk("ctl_hi", `OFS_CONTROL_HI, 32'hff, 32'h38);
    repeat (LOADC + 20) @(posedge CLK);
    rchk("state", `OFS_CURRENT, 32'hc0000000, 32'h80000000);
    wchk("upd_app", `OFS_UPDATE_LO, 32'h0, 2'h2);
  endtask
  // three reloads keep the application alive past one full count
  task t_wdog;
    repeat (3)
    begin
      repeat (4000) @(posedge CLK);
      kick(1'h1);
    end
    chk("still_app", 32'h0, {31'h0, FACTORY_IMAGE});
    wait_fi(1'h1, 12000);
    chk("wd_span", 32'h1, {31'h0, n > 8 * TICK && n < 9 * TICK + 64});
    rchk("ctl_clr", `OFS_CONTROL_HI, '1, 32'h0);
    rchk("wd_status", `OFS_STATUS, 32'h1, 32'h1);
    rchk("rec_one", `OFS_PREV_ONE, '1, 32'h0a00048c);
  endtask
  // three errors at once: external reset must win
  task t_errs;
    wchk("upd_lo", `OFS_UPDATE_LO, 32'h002a5000, 2'h0);
    wchk("upd_hi", `OFS_UPDATE_HI, 32'h30, 2'h0);
    wchk("clksel_wr", `OFS_STATUS, 32'h2, 2'h0);
    rchk("clksel", `OFS_STATUS, 32'h2, 32'h2);
    kick(1'h0);
    n = 0;
    while (LOAD_START !== 1'h1 && n < 200)
    begin
      @(posedge CLK);
      n++;
    end
    chk("load_start", 32'h1, {31'h0, LOAD_START});
    wait_fi(1'h0, 200);
    repeat (LOADC + 20) @(posedge CLK);
    EXT_CONFIG_RESET <= 1'h1;
    CRC_ERROR <= 1'h1;
    CONFIG_STATUS_PIN_N <= 1'h0;
    wait_fi(1'h1, 200);
    EXT_CONFIG_RESET <= 1'h0;
    CRC_ERROR <= 1'h0;
    CONFIG_STATUS_PIN_N <= 1'h1;
    rchk("rec_one", `OFS_PREV_ONE, '1, 32'h42000a94);
    rchk("rec_two", `OFS_PREV_TWO, '1, 32'h0a00048c);
    rchk("ctl_lo", `OFS_CONTROL_LO, '1, 32'h0);
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge CLK);
    RESET <= 1'h0;
    repeat (2) @(posedge CLK);
    t_reset();
    t_boot();
    t_wdog();
    t_errs();
    finish_test();
  end
  // hang guard
  initial
  begin
    #400000;
    miscompares++;
    finish_test();
  end
endmodule
